// ===== bus_seq_regs.vh
// register map, field positions and reset values of the external bus cycle sequencer
`ifndef BUS_SEQ_REGS_VH
`define BUS_SEQ_REGS_VH

`define OFS_TIMING        8'h00
`define OFS_ADDR          8'h04
`define OFS_WDATA         8'h08
`define OFS_CMD           8'h0C
`define OFS_STATUS        8'h10
`define OFS_RDATA         8'h14

`define TIM_AB_LEN        0
`define TIM_AB_EXT_LO     1
`define TIM_AB_EXT_HI     2
`define TIM_CMD_LO        3
`define TIM_CMD_HI        4
`define TIM_WDS           5
`define TIM_ACC_LO        6
`define TIM_ACC_HI        10
`define TIM_HOLD_LO       11
`define TIM_HOLD_HI       12
`define TIM_MUX           13
`define TIM_WIDTH         14
`define TIMING_RESET      14'h0000

`define CMD_READ          0
`define CMD_WRITE         1
`define CMD_HIGH_BYTE     2

`define STAT_BUSY         0
`define STAT_DONE         1

`define CPU_CLOCK_PERIOD_NS 25

`endif

// ===== phase_timer.v
// down counter that times one bus cycle phase in cpu clock periods
module phase_timer #(
  parameter W = 6
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output wire         expired
);

  reg [W-1:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign expired = (cnt_r == {W{1'b0}});

endmodule // phase_timer

// ===== bus_cycle_sequencer.v
// external bus cycle phase sequencer with apb register access
//
// Contract
// - five phases: setup, delay, data setup, access, hold
// - phase lengths come from software timing register
// - setup 1-2 periods, +0-3 on window change
// - command delay 0-3, access 1-32 periods
// - write data setup/tristate phase 0-1 period
// - hold phase 0-3 periods ends cycle
// - read data captured at strobe-rise edge (rdata_r takes din_sync_r there: data_in from two edges before)
// - late address change cannot corrupt read data
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`include "bus_seq_regs.vh"

module bus_cycle_sequencer #(
  parameter AW     = 24,
  parameter DW     = 16,
  parameter WIN_LO = 16
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  output reg  [AW-1:0] addr_out_r,
  output reg  [DW-1:0] data_out_r,
  output reg           data_oe_r,
  input  wire [DW-1:0] data_in,
  output reg           rd_n_r,
  output reg           wr_n_r,
  output reg           ale_r,
  output reg           high_byte_enable_n_r,
  output reg           bus_reference_clock_out
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_AB   = 3'h1;
  localparam [2:0] ST_C    = 3'h2;
  localparam [2:0] ST_D    = 3'h3;
  localparam [2:0] ST_E    = 3'h4;
  localparam [2:0] ST_F    = 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  reg [`TIM_WIDTH-1:0] chip_select_timing_ctrl_r;
  reg [AW-1:0]         addr_r;
  reg [DW-1:0]         wdata_r;
  reg [DW-1:0]         rdata_r;
  reg                  is_write_r;
  reg                  high_byte_r;
  reg                  done_r;
  reg [2:0]            state_r;
  reg [2:0]            state_nxt;
  reg [AW-1:WIN_LO]    last_win_r;
  reg                  win_valid_r;
  reg [DW-1:0]         din_meta_r;
  reg [DW-1:0]         din_sync_r;

  wire       busy    = (state_r != ST_IDLE);
  wire       apb_acc = psel & penable & pready;
  wire       apb_wr  = apb_acc & pwrite;
  wire       start   = apb_wr & (paddr == `OFS_CMD) & ~busy &
                       (pwdata[`CMD_READ] | pwdata[`CMD_WRITE]);
  wire       mapped  = (paddr == `OFS_TIMING) | (paddr == `OFS_ADDR) |
                       (paddr == `OFS_WDATA) | (paddr == `OFS_CMD) |
                       (paddr == `OFS_STATUS) | (paddr == `OFS_RDATA);

  // zero-wait would need a combinational pready; one extra access cycle keeps it a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `OFS_TIMING: prdata <= {{(32-`TIM_WIDTH){1'b0}}, chip_select_timing_ctrl_r};
          `OFS_ADDR:   prdata <= {{(32-AW){1'b0}}, addr_r};
          `OFS_WDATA:  prdata <= {{(32-DW){1'b0}}, wdata_r};
          `OFS_STATUS: prdata <= {30'h0000_0000, done_r, busy};
          `OFS_RDATA:  prdata <= {{(32-DW){1'b0}}, rdata_r};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // settings are locked while a cycle runs so phase lengths stay consistent
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_select_timing_ctrl_r <= `TIMING_RESET;
      addr_r                    <= {AW{1'b0}};
      wdata_r                   <= {DW{1'b0}};
      is_write_r                <= 1'b0;
      high_byte_r               <= 1'b0;
    end else if (apb_wr & ~busy) begin
      case (paddr)
        `OFS_TIMING: chip_select_timing_ctrl_r <= pwdata[`TIM_WIDTH-1:0];
        `OFS_ADDR:   addr_r <= pwdata[AW-1:0];
        `OFS_WDATA:  wdata_r <= pwdata[DW-1:0];
        `OFS_CMD: begin
          is_write_r  <= pwdata[`CMD_WRITE];
          high_byte_r <= pwdata[`CMD_HIGH_BYTE];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // phase lengths

  wire       mux_mode = chip_select_timing_ctrl_r[`TIM_MUX];
  wire       win_chg  = ~win_valid_r | (addr_r[AW-1:WIN_LO] != last_win_r);
  wire [5:0] len_ab   = {5'h00, chip_select_timing_ctrl_r[`TIM_AB_LEN]} + 6'h01 +
                        (win_chg ? {4'h0, chip_select_timing_ctrl_r[`TIM_AB_EXT_HI:`TIM_AB_EXT_LO]}
                                 : 6'h00);
  wire [5:0] len_c    = {4'h0, chip_select_timing_ctrl_r[`TIM_CMD_HI:`TIM_CMD_LO]};
  wire [5:0] len_d    = {5'h00, chip_select_timing_ctrl_r[`TIM_WDS]};
  wire [5:0] len_e    = {1'b0, chip_select_timing_ctrl_r[`TIM_ACC_HI:`TIM_ACC_LO]} + 6'h01;
  wire [5:0] len_f    = {4'h0, chip_select_timing_ctrl_r[`TIM_HOLD_HI:`TIM_HOLD_LO]};

  wire       expired;
  reg  [5:0] load_len;
  wire       entering = (state_nxt != state_r) & (state_nxt != ST_IDLE);

  always @* begin
    case (state_nxt)
      ST_AB:   load_len = len_ab;
      ST_C:    load_len = len_c;
      ST_D:    load_len = len_d;
      ST_E:    load_len = len_e;
      ST_F:    load_len = len_f;
      default: load_len = 6'h01;
    endcase
  end

  phase_timer #(
    .W (6)
  ) u_phase_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (entering),
    .load_val (load_len - 6'h01),
    .expired  (expired)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // phase sequence, zero-length phases are skipped

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start) state_nxt = ST_AB;
      ST_AB: begin
        if (expired) begin
          if (len_c != 6'h00)      state_nxt = ST_C;
          else if (len_d != 6'h00) state_nxt = ST_D;
          else                     state_nxt = ST_E;
        end
      end
      ST_C: begin
        if (expired) begin
          if (len_d != 6'h00) state_nxt = ST_D;
          else                state_nxt = ST_E;
        end
      end
      ST_D: if (expired) state_nxt = ST_E;
      ST_E: begin
        if (expired) begin
          if (len_f != 6'h00) state_nxt = ST_F;
          else                state_nxt = ST_IDLE;
        end
      end
      ST_F: if (expired) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  wire end_access = (state_r == ST_E) & expired;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_IDLE;
      done_r      <= 1'b0;
      last_win_r  <= {(AW-WIN_LO){1'b0}};
      win_valid_r <= 1'b0;
      din_meta_r  <= {DW{1'b0}};
      din_sync_r  <= {DW{1'b0}};
      rdata_r     <= {DW{1'b0}};
    end else begin
      state_r    <= state_nxt;
      din_meta_r <= data_in;
      din_sync_r <= din_meta_r;
      if (start) begin
        done_r      <= 1'b0;
        last_win_r  <= addr_r[AW-1:WIN_LO];
        win_valid_r <= 1'b1;
      end else if (busy & (state_nxt == ST_IDLE)) begin
        done_r <= 1'b1;
      end
      // same edge raises the strobe; the address does not move on it
      if (end_access & ~is_write_r) rdata_r <= din_sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins, all registered from the next state except the toggling reference clock

  wire nxt_busy = (state_nxt != ST_IDLE);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out_r              <= {AW{1'b0}};
      data_out_r              <= {DW{1'b0}};
      data_oe_r               <= 1'b0;
      rd_n_r                  <= 1'b1;
      wr_n_r                  <= 1'b1;
      ale_r                   <= 1'b0;
      high_byte_enable_n_r    <= 1'b1;
      bus_reference_clock_out <= 1'b0;
    end else begin
      bus_reference_clock_out <= ~bus_reference_clock_out;
      // address stays put past the strobe edge that captures data, until the next cycle starts
      if (nxt_busy) addr_out_r <= addr_r;
      // command word lands on the start edge, so its byte flag is taken straight from it
      high_byte_enable_n_r <= start ? ~pwdata[`CMD_HIGH_BYTE] : ~(nxt_busy & high_byte_r);
      ale_r  <= mux_mode & (state_nxt == ST_AB);
      rd_n_r <= ~((state_nxt == ST_E) & ~is_write_r);
      wr_n_r <= ~((state_nxt == ST_E) & is_write_r);
      if (mux_mode & (state_nxt == ST_AB)) begin
        data_out_r <= addr_r[DW-1:0];
        data_oe_r  <= 1'b1;
      end else if (is_write_r & nxt_busy & (state_nxt != ST_AB) &
                   (~mux_mode | (state_nxt != ST_C))) begin
        data_out_r <= wdata_r;
        data_oe_r  <= 1'b1;
      end else begin
        data_oe_r  <= 1'b0;
      end
    end
  end

endmodule // bus_cycle_sequencer

// ===== mem_model.sv
// behavioural external memory on the demultiplexed pins of the sequencer
module mem_model (
  input  wire logic        pclk,
  input  wire logic [23:0] addr_out_r,
  input  wire logic [15:0] data_out_r,
  input  wire logic        rd_n_r,
  input  wire logic        wr_n_r,
  output logic      [15:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:15];
  always @(posedge pclk) begin
    if (!wr_n_r) mem[addr_out_r[3:0]] <= data_out_r;
  end
  // released bus shows the inverse, never a stale match
  assign data_in = rd_n_r ? ~mem[addr_out_r[3:0]] : mem[addr_out_r[3:0]];
endmodule // mem_model

// ===== seq_asserts.sv
// port assertions of the bus cycle sequencer
module seq_asserts #(parameter AW = 24) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [AW-1:0] addr_out_r,
  input wire logic          data_oe_r,
  input wire logic          rd_n_r,
  input wire logic          wr_n_r,
  input wire logic          ale_r,
  input wire logic          bus_reference_clock_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  a_ready_timing: assert property (s_access |=> s_answer)
    else $error("pready timing wrong");
  a_strobe_excl: assert property (rd_n_r || wr_n_r)
    else $error("both strobes low");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
    else $error("pslverr wrong");
  a_ale_first: assert property (ale_r |-> rd_n_r && wr_n_r && data_oe_r)
    else $error("ale outside address phase");
  a_read_float: assert property (!rd_n_r |-> !data_oe_r)
    else $error("driving during read");
  a_addr_hold: assert property (!rd_n_r || !wr_n_r |-> $stable(addr_out_r))
    else $error("address moved under strobe");
  a_write_drive: assert property (!wr_n_r |-> data_oe_r)
    else $error("write data not driven");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_refclk_toggle: assert property ($past(presetn) |-> bus_reference_clock_out != $past(bus_reference_clock_out))
    else $error("reference clock stuck");
endmodule // seq_asserts
bind bus_cycle_sequencer seq_asserts #(.AW(AW)) chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .addr_out_r(addr_out_r), .data_oe_r(data_oe_r), .rd_n_r(rd_n_r),
  .wr_n_r(wr_n_r), .ale_r(ale_r), .bus_reference_clock_out(bus_reference_clock_out));

// ===== test_bus_cycle_sequencer.sv
// self-checking bench of the bus cycle sequencer
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_bus_cycle_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, data_oe_r, rd_n_r, wr_n_r, ale_r, hbe_n, refclk;
  logic [23:0] addr_out_r;
  logic [15:0] data_out_r, data_in, al_d;
  int num_errors = 0, num_checks = 0;
  bus_cycle_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .addr_out_r(addr_out_r), .data_out_r(data_out_r),
    .data_oe_r(data_oe_r), .data_in(data_in), .rd_n_r(rd_n_r), .wr_n_r(wr_n_r),
    .ale_r(ale_r), .high_byte_enable_n_r(hbe_n), .bus_reference_clock_out(refclk));
  mem_model mdl (.pclk(pclk), .addr_out_r(addr_out_r), .data_out_r(data_out_r),
    .rd_n_r(rd_n_r), .wr_n_r(wr_n_r), .data_in(data_in));
  initial forever #12.5 pclk = ~pclk;
  task tally_and_finish;
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin num_errors++; tally_and_finish; end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // one bus cycle; pre = edges to first strobe, low = strobe cycles
  task cyc(input logic [13:0] t, input logic [23:0] a, input logic [15:0] d,
           input logic [2:0] c, input int pre, input int low);
    logic [31:0] r; logic e; int n, m;
    apb(1, 8'h00, {18'h0, t}, r, e);
    apb(1, 8'h04, {8'h0, a}, r, e);
    apb(1, 8'h08, {16'h0, d}, r, e);
    apb(1, 8'h0C, {29'h0, c}, r, e);
    n = 0; al_d = 16'hXXXX;
    #1;
    `CHK(hbe_n, ~c[2])
    do begin if (ale_r === 1'b1) al_d = data_out_r; @(posedge pclk); #1 n++; end
    while (rd_n_r === 1'b1 && wr_n_r === 1'b1 && n < 200);
    `CHK(n, pre)
    `CHK(addr_out_r, a)
    `CHK(hbe_n, ~c[2])
    m = 1;
    while ((rd_n_r === 1'b0 || wr_n_r === 1'b0) && m < 200) begin @(posedge pclk); #1 m++; end
    `CHK(m - 1, low)
    n = 0;
    do begin apb(0, 8'h10, 32'h0, r, e); n++; end while (r[0] !== 1'b0 && n < 20);
    `CHK(r[1:0], 2'b10)
  endtask
  task t_regs;
    logic [31:0] r; logic e;
    apb(0, 8'h00, 32'h0, r, e);
    `CHK(r, 32'h00000000)
    apb(1, 8'h00, 32'hFFFFFFFF, r, e);
    apb(0, 8'h00, 32'h0, r, e);
    `CHK(r, 32'h00003FFF)
    apb(0, 8'h18, 32'h0, r, e);
    `CHK(e, 1'b1)
  endtask
  // timing word: mux hold acc wds cmd ext ab
  task t_slow_write;
    cyc({1'b0, 2'h2, 5'h03, 1'b1, 2'h3, 2'h2, 1'b1}, 24'h120005, 16'hA55A, 3'h2, 8, 4);
  endtask
  task t_same_window_read;
    logic [31:0] r; logic e;
    cyc({1'b0, 2'h2, 5'h03, 1'b1, 2'h3, 2'h2, 1'b1}, 24'h120005, 16'h0, 3'h5, 6, 4);
    apb(0, 8'h14, 32'h0, r, e);
    `CHK(r, 32'h0000A55A)
  endtask
  task t_long_access;
    cyc({1'b0, 2'h0, 5'h1F, 1'b0, 2'h0, 2'h1, 1'b0}, 24'h340003, 16'h0FF0, 3'h2, 2, 32);
  endtask
  task t_mux_read;
    logic [31:0] r; logic e;
    cyc({1'b1, 2'h1, 5'h03, 1'b1, 2'h0, 2'h0, 1'b0}, 24'h340003, 16'h0, 3'h1, 2, 4);
    `CHK(al_d, 16'h0003)
    apb(0, 8'h14, 32'h0, r, e);
    `CHK(r, 32'h00000FF0)
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_slow_write;
    t_same_window_read;
    t_long_access;
    t_mux_read;
    tally_and_finish;
  end
endmodule // test_bus_cycle_sequencer
